/* File: pkg/mailbox_cfg.svh */
// Offsets, field positions, reset values and timing counts of the mailbox port
`ifndef MAILBOX_CFG_SVH
`define MAILBOX_CFG_SVH
`define MBX_ADDR_DATA0 8'h20
`define MBX_ADDR_DATA1 8'h21
`define MBX_ADDR_DATA2 8'h22
`define MBX_ADDR_FLAGS 8'h23
`define MBX_ADDR_SETUP 8'h24
`define MBX_EXT_FLAGS 2'h3
`define MBX_FLAG_IRQ_IN 7
`define MBX_FLAG_FULL_IN_LSB 4
`define MBX_FLAG_ATTN 3
`define MBX_FLAG_FULL_OUT_LSB 0
`define MBX_SETUP_IGNORE_MODE 7
`define MBX_SETUP_MODE_MSB 6
`define MBX_SETUP_MODE_LSB 5
`define MBX_SETUP_SLAVE_EN 3
`define MBX_SETUP_PORTA_OUT 2
`define MBX_SETUP_PRIO_MSB 1
`define MBX_SETUP_PRIO_LSB 0
`define MBX_SETUP_RESET 8'h00
`define MBX_DATA_RESET 8'h00
`define MBX_BOOT_CODE 2'h1
`define MBX_RUN_CODE 2'h0
`define MBX_BOOT_SETTLE 2'h3
`endif

/* File: pkg/mailbox_pkg.sv */
// Types shared by the mailbox port
package mailbox_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [1:0] ext_addr_t;
  typedef enum logic [1:0] {BOOT_SETTLE, BOOT_LOAD, BOOT_IDLE} boot_state_e;
endpackage

/* File: sim/mailbox_master_model.sv */
// Behavioural external master driving the mailbox port pins
`timescale 1ns/100ps
module mailbox_master_model (
  input wire logic clock,
  output logic sel_n,
  output logic rd_n,
  output logic wr_n,
  output logic [1:0] code,
  output mailbox_pkg::byte_t bus,
  input wire mailbox_pkg::byte_t dev_data,
  input wire logic dev_oe_n
);
  import mailbox_pkg::*;
  byte_t drive_q;
  byte_t last_q = 8'hA5;
  logic driving = 1'h0;
  // Released bus shows the inverse of its last level
  assign bus = !dev_oe_n ? dev_data : (driving ? drive_q : ~last_q);
  always @(posedge clock) begin
    if (driving || !dev_oe_n) begin
      last_q <= bus;
    end
  end
  initial begin
    sel_n = 1'h1;
    rd_n = 1'h1;
    wr_n = 1'h1;
    code = 2'h0;
    drive_q = 8'h00;
  end
  task automatic access(input logic sel, input logic wr, input logic [1:0] c,
    input byte_t wdata, input logic sel_first, output byte_t rdata, output logic oe_seen);
    @(posedge clock);
    #1;
    code = c;
    drive_q = wdata;
    driving = wr;
    sel_n = !sel;
    repeat (2) @(posedge clock);
    #1;
    wr_n = !wr;
    rd_n = wr;
    repeat (6) @(posedge clock);
    #1;
    rdata = bus;
    oe_seen = !dev_oe_n;
    if (sel_first) begin
      sel_n = 1'h1;
      repeat (2) @(posedge clock);
      #1;
    end
    wr_n = 1'h1;
    rd_n = 1'h1;
    sel_n = 1'h1;
    // Gap keeps reads clear of the other side's writes
    repeat (6) @(posedge clock);
    #1;
    driving = 1'h0;
  endtask
endmodule

/* File: sim/tb_top.sv */
// Self-checking bench for the mailbox port
`timescale 1ns/100ps
module tb_top;
  import mailbox_pkg::*;
  logic clock, reset_n, sel_n, rd_n, wr_n, boot0, boot1, io_wr, io_rd;
  logic oe_n, attention_n, slave_irq, cold_boot, run_start, oe_seen;
  logic [1:0] code, prio;
  byte_t bus, dout, a_in, a_out, io_addr, io_wdata, io_rdata, rd_v;
  int mismatches = 0;
  int samples_checked = 0;
  processor_slave_mailbox_port i_processor_slave_mailbox_port (
    .clock(clock), .reset_n(reset_n), .port_select_n(sel_n),
    .port_read_strobe_n(rd_n), .port_write_strobe_n(wr_n),
    .reg_select_bit0(code[0]), .reg_select_bit1(code[1]), .port_data_in(bus),
    .port_data_out(dout), .port_data_oe_n(oe_n), .attention_n(attention_n),
    .boot_mode_pin0(boot0), .boot_mode_pin1(boot1), .port_a_out_value(a_out),
    .port_a_in_value(a_in), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .slave_irq(slave_irq),
    .slave_irq_priority(prio), .cold_boot(cold_boot), .run_start(run_start));
  mailbox_master_model i_mailbox_master_model (.clock(clock), .sel_n(sel_n),
    .rd_n(rd_n), .wr_n(wr_n), .code(code), .bus(bus), .dev_data(dout), .dev_oe_n(oe_n));
  initial begin
    clock = 1'h0;
    forever #4 clock = ~clock;
  end
  task automatic results;
    if (mismatches == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic check(input string name, input byte_t seen, input byte_t exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask
  task automatic do_reset(input logic b1, input logic b0);
    @(posedge clock);
    #1;
    reset_n = 1'h0;
    boot1 = b1;
    boot0 = b0;
    repeat (12) @(posedge clock);
    #1;
    reset_n = 1'h1;
    repeat (8) @(posedge clock);
    #1;
  endtask
  task automatic core_wr(input byte_t a, input byte_t d);
    @(posedge clock);
    #1;
    io_addr = a;
    io_wdata = d;
    io_wr = 1'h1;
    @(posedge clock);
    #1;
    io_wr = 1'h0;
    @(posedge clock);
    #1;
  endtask
  task automatic core_chk(input byte_t a, input byte_t exp);
    @(posedge clock);
    #1;
    io_addr = a;
    io_rd = 1'h1;
    @(posedge clock);
    #1;
    io_rd = 1'h0;
    check($sformatf("core reg %h", a), io_rdata, exp);
  endtask
  task automatic mw(input logic [1:0] c, input byte_t d, input logic sf);
    i_mailbox_master_model.access(1'h1, 1'h1, c, d, sf, rd_v, oe_seen);
  endtask
  task automatic m_chk(input logic [1:0] c, input byte_t exp);
    i_mailbox_master_model.access(1'h1, 1'h0, c, 8'h00, 1'h0, rd_v, oe_seen);
    check("master drive", {7'h0, oe_seen}, 8'h01);
    check($sformatf("master reg %h", c), rd_v, exp);
  endtask
  task automatic t_disabled;
    check("attention", {7'h0, attention_n}, 8'h01);
    check("irq", {7'h0, slave_irq}, 8'h00);
    core_chk(8'h24, 8'h00);
    core_chk(8'h25, 8'h00);
    mw(2'h0, 8'h11, 1'h0);
    i_mailbox_master_model.access(1'h1, 1'h0, 2'h0, 8'h00, 1'h0, rd_v, oe_seen);
    check("drive disabled", {7'h0, oe_seen}, 8'h00);
    core_chk(8'h23, 8'h00);
    core_wr(8'h24, 8'h04);
    repeat (4) @(posedge clock);
    #1;
    check("port A drive", {7'h0, oe_n}, 8'h00);
    check("port A out", dout, 8'h3C);
    check("port A in", a_in, 8'h3C);
    core_wr(8'h24, 8'h00);
    check("port A release", {7'h0, oe_n}, 8'h01);
  endtask
  task automatic t_select_high;
    core_wr(8'h24, 8'h09);
    check("priority", {6'h0, prio}, 8'h01);
    i_mailbox_master_model.access(1'h0, 1'h1, 2'h1, 8'h33, 1'h0, rd_v, oe_seen);
    i_mailbox_master_model.access(1'h0, 1'h0, 2'h1, 8'h00, 1'h0, rd_v, oe_seen);
    check("drive deselected", {7'h0, oe_seen}, 8'h00);
    core_chk(8'h23, 8'h00);
    core_chk(8'h21, 8'h00);
  endtask
  task automatic t_m2s;
    mw(2'h0, 8'hA1, 1'h0);
    mw(2'h1, 8'hB2, 1'h1);
    mw(2'h2, 8'hC3, 1'h0);
    check("irq", {7'h0, slave_irq}, 8'h01);
    core_chk(8'h23, 8'hF0);
    core_chk(8'h20, 8'hA1);
    core_chk(8'h21, 8'hB2);
    core_chk(8'h22, 8'hC3);
    core_chk(8'h23, 8'h80);
    core_wr(8'h23, 8'hFF);
    core_chk(8'h23, 8'h00);
    check("irq", {7'h0, slave_irq}, 8'h00);
  endtask
  task automatic t_s2m;
    core_wr(8'h20, 8'h5A);
    check("attention", {7'h0, attention_n}, 8'h00);
    core_wr(8'h21, 8'h6B);
    core_wr(8'h22, 8'h7C);
    m_chk(2'h3, 8'h0F);
    m_chk(2'h0, 8'h5A);
    m_chk(2'h1, 8'h6B);
    m_chk(2'h2, 8'h7C);
    m_chk(2'h3, 8'h08);
    mw(2'h3, 8'h00, 1'h0);
    check("attention", {7'h0, attention_n}, 8'h01);
    core_chk(8'h23, 8'h00);
  endtask
  task automatic t_priority;
    core_wr(8'h24, 8'h08);
    mw(2'h0, 8'h01, 1'h0);
    check("irq off", {7'h0, slave_irq}, 8'h00);
    core_chk(8'h23, 8'h90);
    core_wr(8'h23, 8'h00);
    core_chk(8'h20, 8'h01);
    core_chk(8'h23, 8'h00);
  endtask
  task automatic t_cold_boot;
    int n;
    do_reset(1'h0, 1'h1);
    check("cold boot", {7'h0, cold_boot}, 8'h01);
    core_chk(8'h24, 8'h28);
    mw(2'h0, 8'h5A, 1'h0);
    core_chk(8'h20, 8'h5A);
    boot0 = 1'h0;
    for (n = 0; n < 40 && run_start !== 1'h1; n++) begin
      @(posedge clock);
      #1;
    end
    check("run start", {7'h0, run_start}, 8'h01);
    repeat (2) @(posedge clock);
    #1;
    check("cold boot end", {7'h0, cold_boot}, 8'h00);
  endtask
  task automatic t_ignore_mode;
    do_reset(1'h0, 1'h1);
    check("cold boot", {7'h0, cold_boot}, 8'h01);
    core_wr(8'h24, 8'h88);
    check("boot aborted", {7'h0, cold_boot}, 8'h00);
    core_chk(8'h24, 8'hA8);
    boot0 = 1'h0;
    repeat (6) begin
      @(posedge clock);
      #1;
      check("no run start", {7'h0, run_start}, 8'h00);
    end
  endtask
  initial begin
    reset_n = 1'h0;
    boot0 = 1'h0;
    boot1 = 1'h0;
    io_wr = 1'h0;
    io_rd = 1'h0;
    io_addr = 8'h00;
    io_wdata = 8'h00;
    a_out = 8'h3C;
    do_reset(1'h0, 1'h0);
    t_disabled;
    t_select_high;
    t_m2s;
    t_s2m;
    t_priority;
    t_cold_boot;
    t_ignore_mode;
    results;
  end
  initial begin
    #400000;
    mismatches++;
    results;
  end
endmodule

/* File: src/processor_slave_mailbox_port.sv */
// Byte-wide mailbox port between an external master and the slave core
// How it works
// - Three inbound and three outbound data registers, each pair at one address.
// - Each data register has a full flag: write sets, other side's read clears.
// - Both core and master may read the flag register with all six flags.
// - Master write to register zero sets inbound interrupt; enabled priority requests core.
// - Core write to register zero drives attention_n low.
// - Flag register write by a side clears that side's interrupt source; data ignored.
// - Data lines driven only while select and read strobe are both low, or in port A output mode.
// - Master requests ignored while port_select_n is high.
// - Read places addressed register on lines; codes 0-2 data, 3 flags.
// - Write captured when write strobe or select rises, whichever first.
// - Data pins serve the slave port only when setup register enables it.
// - After reset pins are port inputs; boot pins (0,1) enable port and cold boot.
// - Core reaches registers at 0x20-0x24; setup register hidden from master.
// - Setup bits 3:2 pick pin use, bits 1:0 interrupt priority, 00 off.
// - Flag bits 6:4, 2:0 full; bit 7 inbound interrupt, bit 3 attention.
// - Cold boot ends when boot pins become (0,0); core starts at zero.
`timescale 1ns/100ps
`include "mailbox_cfg.svh"
module processor_slave_mailbox_port (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic port_select_n,
  input wire logic port_read_strobe_n,
  input wire logic port_write_strobe_n,
  input wire logic reg_select_bit0,
  input wire logic reg_select_bit1,
  input wire mailbox_pkg::byte_t port_data_in,
  output mailbox_pkg::byte_t port_data_out,
  output logic port_data_oe_n,
  output logic attention_n,
  input wire logic boot_mode_pin0,
  input wire logic boot_mode_pin1,
  input wire mailbox_pkg::byte_t port_a_out_value,
  output mailbox_pkg::byte_t port_a_in_value,
  input wire mailbox_pkg::byte_t io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire mailbox_pkg::byte_t io_wdata,
  output mailbox_pkg::byte_t io_rdata,
  output logic slave_irq,
  output logic [1:0] slave_irq_priority,
  output logic cold_boot,
  output logic run_start
);
  import mailbox_pkg::*;

  // Two-stage synchronisers for every pin input
  logic [14:0] pin_meta_q;
  logic [14:0] pin_sync_q;
  always_ff @(posedge clock) begin
    pin_meta_q <= {boot_mode_pin1, boot_mode_pin0, reg_select_bit1, reg_select_bit0,
                   port_select_n, port_read_strobe_n, port_write_strobe_n, port_data_in};
    pin_sync_q <= pin_meta_q;
  end

  logic [1:0] mode_s;
  ext_addr_t addr_s;
  logic sel_n_s, rd_n_s, wr_n_s;
  byte_t data_s;
  assign {mode_s, addr_s, sel_n_s, rd_n_s, wr_n_s, data_s} = pin_sync_q;

  byte_t setup_q;
  logic slave_en;
  assign slave_en = setup_q[`MBX_SETUP_SLAVE_EN];

  logic m_wr_act, m_rd_act;
  assign m_wr_act = slave_en & ~sel_n_s & ~wr_n_s;
  assign m_rd_act = slave_en & ~sel_n_s & ~rd_n_s;

  // Master write: track address and data, commit when access ends
  logic m_wr_act_q, m_rd_act_q;
  ext_addr_t m_wr_addr_q, m_rd_addr_q;
  byte_t m_wr_data_q;
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      m_wr_act_q <= 1'b0;
      m_rd_act_q <= 1'b0;
      m_wr_addr_q <= 2'h0;
      m_rd_addr_q <= 2'h0;
      m_wr_data_q <= `MBX_DATA_RESET;
    end else begin
      m_wr_act_q <= m_wr_act;
      m_rd_act_q <= m_rd_act;
      if (m_wr_act) begin
        m_wr_addr_q <= addr_s;
        m_wr_data_q <= data_s;
      end
      if (m_rd_act) begin
        m_rd_addr_q <= addr_s;
      end
    end
  end

  logic m_wr_done, m_rd_done;
  assign m_wr_done = m_wr_act_q & ~m_wr_act;
  assign m_rd_done = m_rd_act_q & ~m_rd_act;

  logic s_wr, s_rd;
  assign s_wr = io_wr & ~io_rd;
  assign s_rd = io_rd & ~io_wr;

  // Data registers and full flags
  byte_t in_data_q [3];
  byte_t out_data_q [3];
  logic [2:0] full_in_q, full_out_q;
  for (genvar i = 0; i < 3; i++) begin : g_mbox
    localparam byte_t SLOT = `MBX_ADDR_DATA0 + byte_t'(i);
    localparam ext_addr_t EXT = ext_addr_t'(i);
    always_ff @(posedge clock) begin
      if (!reset_n) begin
        in_data_q[i] <= `MBX_DATA_RESET;
        out_data_q[i] <= `MBX_DATA_RESET;
      end else begin
        if (m_wr_done && m_wr_addr_q == EXT) begin
          in_data_q[i] <= m_wr_data_q;
        end
        if (s_wr && io_addr == SLOT) begin
          out_data_q[i] <= io_wdata;
        end
      end
    end
    always_ff @(posedge clock) begin
      if (!reset_n) begin
        full_in_q[i] <= 1'b0;
        full_out_q[i] <= 1'b0;
      end else begin
        if (m_wr_done && m_wr_addr_q == EXT) begin
          full_in_q[i] <= 1'b1;
        end else if (s_rd && io_addr == SLOT) begin
          full_in_q[i] <= 1'b0;
        end
        if (s_wr && io_addr == SLOT) begin
          full_out_q[i] <= 1'b1;
        end else if (m_rd_done && m_rd_addr_q == EXT) begin
          full_out_q[i] <= 1'b0;
        end
      end
    end
  end

  // Interrupt sources; a set beats a clear in the same cycle
  logic irq_in_q, attn_q;
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      irq_in_q <= 1'b0;
      attn_q <= 1'b0;
    end else begin
      if (m_wr_done && m_wr_addr_q == 2'h0) begin
        irq_in_q <= 1'b1;
      end else if (s_wr && io_addr == `MBX_ADDR_FLAGS) begin
        irq_in_q <= 1'b0;
      end
      if (s_wr && io_addr == `MBX_ADDR_DATA0) begin
        attn_q <= 1'b1;
      end else if (m_wr_done && m_wr_addr_q == `MBX_EXT_FLAGS) begin
        attn_q <= 1'b0;
      end
    end
  end

  byte_t flags;
  always_comb begin
    flags = 8'h00;
    flags[`MBX_FLAG_IRQ_IN] = irq_in_q;
    flags[`MBX_FLAG_FULL_IN_LSB +: 3] = full_in_q;
    flags[`MBX_FLAG_ATTN] = attn_q;
    flags[`MBX_FLAG_FULL_OUT_LSB +: 3] = full_out_q;
  end

  // Boot sequencing from the mode pins
  boot_state_e boot_q;
  logic [1:0] settle_q;
  logic boot_hit, run_hit;
  assign boot_hit = boot_q == BOOT_SETTLE && settle_q == `MBX_BOOT_SETTLE
                    && mode_s == `MBX_BOOT_CODE && !setup_q[`MBX_SETUP_IGNORE_MODE];
  assign run_hit = boot_q == BOOT_LOAD && mode_s == `MBX_RUN_CODE;
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      boot_q <= BOOT_SETTLE;
      settle_q <= 2'h0;
      run_start <= 1'b0;
      cold_boot <= 1'b0;
    end else begin
      run_start <= 1'b0;
      case (boot_q)
        BOOT_SETTLE: begin
          settle_q <= settle_q + 2'h1;
          if (boot_hit) begin
            boot_q <= BOOT_LOAD;
            cold_boot <= 1'b1;
          end else if (settle_q == `MBX_BOOT_SETTLE) begin
            boot_q <= BOOT_IDLE;
          end
        end
        BOOT_LOAD: begin
          if (setup_q[`MBX_SETUP_IGNORE_MODE]) begin
            boot_q <= BOOT_IDLE;
            cold_boot <= 1'b0;
          end else if (run_hit) begin
            boot_q <= BOOT_IDLE;
            cold_boot <= 1'b0;
            run_start <= 1'b1;
          end
        end
        BOOT_IDLE: boot_q <= BOOT_IDLE;
        default: boot_q <= BOOT_IDLE;
      endcase
    end
  end

  // Setup register: core side only
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      setup_q <= `MBX_SETUP_RESET;
    end else if (s_wr && io_addr == `MBX_ADDR_SETUP) begin
      setup_q <= io_wdata;
    end else if (boot_hit) begin
      setup_q[`MBX_SETUP_SLAVE_EN] <= 1'b1;
    end
  end

  // Core read port
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      io_rdata <= 8'h00;
    end else if (s_rd) begin
      case (io_addr)
        `MBX_ADDR_DATA0: io_rdata <= in_data_q[0];
        `MBX_ADDR_DATA1: io_rdata <= in_data_q[1];
        `MBX_ADDR_DATA2: io_rdata <= in_data_q[2];
        `MBX_ADDR_FLAGS: io_rdata <= flags;
        `MBX_ADDR_SETUP: begin
          io_rdata <= {setup_q[7], mode_s, setup_q[4:0]};
        end
        default: io_rdata <= 8'h00;
      endcase
    end
  end

  // Master read data and pin direction
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      port_data_out <= 8'h00;
      port_data_oe_n <= 1'b1;
      port_a_in_value <= 8'h00;
    end else begin
      port_a_in_value <= data_s;
      if (m_rd_act) begin
        case (addr_s)
          2'h0: port_data_out <= out_data_q[0];
          2'h1: port_data_out <= out_data_q[1];
          2'h2: port_data_out <= out_data_q[2];
          default: port_data_out <= flags;
        endcase
        port_data_oe_n <= 1'b0;
      end else if (!slave_en && setup_q[`MBX_SETUP_PORTA_OUT]) begin
        port_data_out <= port_a_out_value;
        port_data_oe_n <= 1'b0;
      end else begin
        port_data_oe_n <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      attention_n <= 1'b1;
      slave_irq <= 1'b0;
      slave_irq_priority <= 2'h0;
    end else begin
      attention_n <= ~attn_q;
      slave_irq <= irq_in_q && setup_q[`MBX_SETUP_PRIO_MSB:`MBX_SETUP_PRIO_LSB] != 2'h0;
      slave_irq_priority <= setup_q[`MBX_SETUP_PRIO_MSB:`MBX_SETUP_PRIO_LSB];
    end
  end

  chk_in_flag_set: assert property (@(posedge clock) disable iff (!reset_n)
    m_wr_done && m_wr_addr_q != `MBX_EXT_FLAGS |=> full_in_q[m_wr_addr_q])
    else $error("inbound full flag not set");
  chk_out_flag_set: assert property (@(posedge clock) disable iff (!reset_n)
    s_wr && io_addr == `MBX_ADDR_DATA1 |=> full_out_q[1])
    else $error("outbound full flag not set");
  chk_read_clear: assert property (@(posedge clock) disable iff (!reset_n)
    $fell(full_out_q[0]) |-> $past(m_rd_done) && !m_rd_act)
    else $error("outbound flag cleared outside read end");
  chk_irq_set: assert property (@(posedge clock) disable iff (!reset_n)
    m_wr_done && m_wr_addr_q == 2'h0 && setup_q[1:0] != 2'h0
    && !(s_wr && io_addr == `MBX_ADDR_SETUP) |=> ##1 slave_irq)
    else $error("slave interrupt missing");
  chk_attn_low: assert property (@(posedge clock) disable iff (!reset_n)
    s_wr && io_addr == `MBX_ADDR_DATA0 |=> ##1 !attention_n)
    else $error("attention not asserted");
  chk_attn_clear: assert property (@(posedge clock) disable iff (!reset_n)
    m_wr_done && m_wr_addr_q == 2'h3 && !(s_wr && io_addr == `MBX_ADDR_DATA0)
    |=> ##1 attention_n)
    else $error("attention not released");
  chk_drive_window: assert property (@(posedge clock) disable iff (!reset_n)
    !port_data_oe_n && $past(slave_en) |-> $past(m_rd_act))
    else $error("data lines driven outside read");
  chk_ignore_idle: assert property (@(posedge clock) disable iff (!reset_n)
    $past(sel_n_s) && $past(slave_en) |-> port_data_oe_n)
    else $error("data lines driven while deselected");
  chk_boot_enable: assert property (@(posedge clock) disable iff (!reset_n)
    boot_hit && !(s_wr && io_addr == `MBX_ADDR_SETUP) |=> slave_en && cold_boot)
    else $error("cold boot did not enable port");
  chk_run_pulse: assert property (@(posedge clock) disable iff (!reset_n)
    run_start |=> !run_start && !cold_boot)
    else $error("run start not a single pulse");
  cov_master_write: cover property (@(posedge clock) disable iff (!reset_n)
    m_wr_done && m_wr_addr_q == 2'h0);
  cov_master_read: cover property (@(posedge clock) disable iff (!reset_n)
    m_rd_done && full_out_q[0]);
  cov_cold_boot: cover property (@(posedge clock) disable iff (!reset_n) run_start);
endmodule
